// ==== rtl/dsli_map.svh ====
// register offsets, field positions, reset values and timing counts of the lamp block
`ifndef DSLI_MAP_SVH
`define DSLI_MAP_SVH
`define DSLI_CLK_HZ        40000000
`define DSLI_SLOT_MS       125
`define DSLI_PERIOD_MS     3000
`define DSLI_SLOT_CYCLES   ((`DSLI_CLK_HZ / 1000) * `DSLI_SLOT_MS)
`define DSLI_SLOTS         (`DSLI_PERIOD_MS / `DSLI_SLOT_MS)
`define DSLI_ADDR_CTRL     4'h0
`define DSLI_ADDR_STATUS   4'h1
`define DSLI_ADDR_IRQ      4'h2
`define DSLI_ADDR_MASK     4'h3
`define DSLI_ADDR_PINDEX   4'h4
`define DSLI_ADDR_PWIN     4'h5
`define DSLI_ADDR_PDATA    4'h6
`define DSLI_CTRL_RESET    32'h0000_0000
`define DSLI_MASK_RESET    32'h0000_0000
`define DSLI_CTRL_OVR_EN   0
`define DSLI_CTRL_OS_OK    1
`define DSLI_CTRL_PAT_LSB  4
`define DSLI_IRQ_READY_UP  0
`define DSLI_IRQ_READY_DN  1
`define DSLI_IRQ_PERM      2
`define DSLI_IRQ_RUN_CHG   3
`define DSLI_IRQ_BITS      4
`endif

// ==== rtl/dsli_pkg.sv ====
// types of the lamp block
package dsli_pkg;
  typedef enum logic [1:0] {
    dsli_green_off   = 2'b00,
    dsli_green_blink = 2'b01,
    dsli_green_on    = 2'b10
  } dsli_green_t;
  typedef logic [31:0] dsli_word_t;
endpackage

// ==== rtl/dsli_pattern_mem.sv ====
// pattern table: one word per state, three lamp bits per slot
`timescale 1ns/1ps
module dsli_pattern_mem #(
  parameter int DEPTH = 8,
  parameter int AW    = 3,
  parameter int DW    = 72
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];
  initial begin
    if (DEPTH > (1 << AW)) $error("depth exceeds address range");
  end
  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= mem[raddr];
    end
  end
endmodule

// ==== rtl/dsli_slot_timer.sv ====
// slot and period timer: slot pulse and slot index
`timescale 1ns/1ps
`include "dsli_map.svh"
module dsli_slot_timer #(
  parameter int SLOT_CYCLES = `DSLI_SLOT_CYCLES,
  parameter int SLOTS       = `DSLI_SLOTS
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  output logic            slot_tick,
  output logic [4:0]      slot_idx
);
  logic [22:0] cnt;
  logic [22:0] next_cnt;
  logic [4:0]  next_idx;
  logic        next_tick;
  initial begin
    if (SLOT_CYCLES < 1 || SLOT_CYCLES > (1 << 23)) $error("slot length out of range");
    if (SLOTS < 2 || SLOTS > 32) $error("slot count out of range");
  end
  // ------------------------------------------------------------
  // slot counting
  // ------------------------------------------------------------
  always_comb begin
    next_cnt  = cnt + 23'h1;
    next_idx  = slot_idx;
    next_tick = 1'b0;
    if (cnt == 23'(SLOT_CYCLES - 1)) begin
      next_cnt  = '0;
      next_tick = 1'b1; // RULE7
      if (slot_idx == 5'(SLOTS - 1)) begin
        next_idx = '0; // RULE8
      end else begin
        next_idx = slot_idx + 5'h1;
      end
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt       <= '0;
      slot_idx  <= '0;
      slot_tick <= 1'b0;
    end else if (ce) begin
      cnt       <= next_cnt;
      slot_idx  <= next_idx;
      slot_tick <= next_tick;
    end
  end
endmodule

// ==== rtl/dsli_led_top.sv ====
// Behaviour
// RULE1: green steady only when booted, no error pending, power stage may enable.
// RULE2: green blinks whenever not ready: bus voltage, motor or module overheat.
// RULE3: missing signal on either enable input means not ready, green blinks.
// RULE4: missing or faulty feedback or temperature sensor means not ready.
// RULE5: orange lit exactly while the power stage is enabled.
// RULE6: red lit while a permanent error is present.
// RULE7: every pattern built from whole 125 ms slots.
// RULE8: patterns repeat every 3000 ms, restarting at slot zero.
// RULE9: boot and module error states select slot patterns from a writable table; the code reads the entry named in CTRL, used only under override.
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "dsli_map.svh"
module dsli_led_top
  import dsli_pkg::*;
#(
  parameter int SLOT_CYCLES = `DSLI_SLOT_CYCLES,
  parameter int SLOTS       = `DSLI_SLOTS,
  parameter int PAT_STATES  = 8
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             ce,
  input  wire logic             enable_a,
  input  wire logic             enable_b,
  input  wire logic             dc_bus_ok,
  input  wire logic             motor_overtemp,
  input  wire logic             module_overtemp,
  input  wire logic             feedback_fault,
  input  wire logic             temp_sensor_fault,
  input  wire logic             temp_error,
  input  wire logic             perm_error,
  input  wire logic             power_stage_on,
  input  wire logic [3:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire dsli_pkg::dsli_word_t avs_writedata,
  output dsli_pkg::dsli_word_t  avs_readdata,
  output logic                  avs_waitrequest,
  output logic                  led_green,
  output logic                  led_orange,
  output logic                  led_red,
  output logic                  irq
);
  import dsli_pkg::*;
  localparam int PW = 3 * SLOTS;
  initial begin
    if (PAT_STATES < 1 || PAT_STATES > 8) $error("pattern states out of range");
    if (PW > 96) $error("pattern too wide");
  end

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  localparam int NIN = 11;
  logic [NIN-1:0] s1;
  logic [NIN-1:0] s2;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1 <= '0;
      s2 <= '0;
    end else if (ce) begin
      s1 <= {power_stage_on, perm_error, temp_error, temp_sensor_fault, feedback_fault,
             module_overtemp, motor_overtemp, dc_bus_ok, enable_b, enable_a, 1'b0};
      s2 <= s1;
    end
  end
  logic en_a_s, en_b_s, bus_ok_s, mot_ot_s, mod_ot_s, fb_f_s, ts_f_s, tmp_e_s;
  logic perm_s, pwr_s;
  assign {pwr_s, perm_s, tmp_e_s, ts_f_s, fb_f_s, mod_ot_s, mot_ot_s, bus_ok_s,
          en_b_s, en_a_s} = s2[NIN-1:1];

  // ------------------------------------------------------------
  // slot timer and pattern table
  // ------------------------------------------------------------
  logic       slot_tick;
  logic [4:0] slot_idx;
  dsli_slot_timer #(
    .SLOT_CYCLES (SLOT_CYCLES),
    .SLOTS       (SLOTS)
  ) u_timer (
    .clk       (clk),
    .nrst      (nrst),
    .ce        (ce),
    .slot_tick (slot_tick),
    .slot_idx  (slot_idx)
  );

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  dsli_word_t ctrl, next_ctrl;
  dsli_word_t mask, next_mask;
  logic [`DSLI_IRQ_BITS-1:0] irq_st, next_irq_st;
  logic [2:0]  pidx, next_pidx;
  logic [1:0]  pwin, next_pwin;
  logic [95:0] pstage, next_pstage;
  logic        pwe, next_pwe;
  dsli_word_t  rdata_q, next_rdata;
  logic        ack, next_ack;
  logic [PW-1:0] pat_rd;

  dsli_pattern_mem #(
    .DEPTH (PAT_STATES),
    .AW    (3),
    .DW    (PW)
  ) u_mem (
    .clk   (clk),
    .nrst  (nrst),
    .ce    (ce),
    .we    (pwe),
    .waddr (pidx),
    .wdata (pstage[PW-1:0]),
    .raddr (ctrl[`DSLI_CTRL_PAT_LSB +: 3]), // RULE9
    .rdata (pat_rd)
  );

  // ------------------------------------------------------------
  // readiness decision
  // ------------------------------------------------------------
  logic not_ready, ready;
  always_comb begin
    not_ready = !en_a_s || !en_b_s; // RULE3
    not_ready = not_ready || !bus_ok_s || mot_ot_s || mod_ot_s; // RULE2
    not_ready = not_ready || fb_f_s || ts_f_s; // RULE4
    ready = ctrl[`DSLI_CTRL_OS_OK] && !tmp_e_s && !perm_s && !not_ready; // RULE1
  end

  // ------------------------------------------------------------
  // lamp drive
  // ------------------------------------------------------------
  dsli_green_t gmode;
  logic next_green, next_orange, next_red;
  logic [2:0] pslot;
  logic prev_ready, prev_perm, prev_pwr;
  always_comb begin
    pslot = 3'(pat_rd >> (3 * slot_idx));
    if (!ctrl[`DSLI_CTRL_OS_OK]) begin
      gmode = dsli_green_off;
    end else if (ready) begin
      gmode = dsli_green_on;
    end else begin
      gmode = dsli_green_blink;
    end
    case (gmode)
      dsli_green_on:    next_green = 1'b1; // RULE1
      dsli_green_blink: next_green = !slot_idx[0]; // RULE2 RULE7
      default:          next_green = 1'b0;
    endcase
    next_orange = pwr_s; // RULE5
    next_red    = perm_s; // RULE6
    if (ctrl[`DSLI_CTRL_OVR_EN]) begin
      next_green  = pslot[0]; // RULE9
      next_orange = pslot[1];
      next_red    = pslot[2];
    end
  end
  logic g_q, o_q, r_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      g_q <= 1'b0;
      o_q <= 1'b0;
      r_q <= 1'b0;
    end else if (ce) begin
      if (slot_tick || ctrl[`DSLI_CTRL_OVR_EN] == 1'b0) begin
        g_q <= next_green; // RULE7
      end
      o_q <= next_orange;
      r_q <= next_red;
    end
  end
  assign led_green  = g_q;
  assign led_orange = o_q;
  assign led_red    = r_q;

  // ------------------------------------------------------------
  // bus and interrupt next state
  // ------------------------------------------------------------
  logic [`DSLI_IRQ_BITS-1:0] ev;
  logic next_irq, irq_q;
  always_comb begin
    ev = '0;
    ev[`DSLI_IRQ_READY_UP] = ready && !prev_ready;
    ev[`DSLI_IRQ_READY_DN] = !ready && prev_ready;
    ev[`DSLI_IRQ_PERM]     = perm_s && !prev_perm;
    ev[`DSLI_IRQ_RUN_CHG]  = pwr_s != prev_pwr;
    next_ctrl   = ctrl;
    next_mask   = mask;
    next_pidx   = pidx;
    next_pwin   = pwin;
    next_pstage = pstage;
    next_pwe    = 1'b0;
    next_rdata  = rdata_q;
    next_ack    = 1'b0;
    next_irq_st = irq_st;
    if ((avs_read || avs_write) && !ack) begin
      next_ack = 1'b1;
      if (avs_write) begin
        case (avs_address)
          `DSLI_ADDR_CTRL:   next_ctrl = avs_writedata;
          `DSLI_ADDR_IRQ:    next_irq_st = irq_st & ~avs_writedata[`DSLI_IRQ_BITS-1:0];
          `DSLI_ADDR_MASK:   next_mask = avs_writedata;
          `DSLI_ADDR_PINDEX: next_pidx = avs_writedata[2:0];
          `DSLI_ADDR_PWIN:   next_pwin = avs_writedata[1:0];
          `DSLI_ADDR_PDATA: begin
            next_pstage[32*pwin +: 32] = avs_writedata;
            next_pwe = 1'b1;
          end
          default: next_ack = 1'b1;
        endcase
      end else begin
        case (avs_address)
          `DSLI_ADDR_CTRL:   next_rdata = ctrl;
          `DSLI_ADDR_STATUS: next_rdata = {22'h0, slot_idx, r_q, o_q, g_q, ready, pwr_s};
          `DSLI_ADDR_IRQ:    next_rdata = 32'(irq_st);
          `DSLI_ADDR_MASK:   next_rdata = mask;
          `DSLI_ADDR_PINDEX: next_rdata = 32'(pidx);
          `DSLI_ADDR_PWIN:   next_rdata = 32'(pwin);
          `DSLI_ADDR_PDATA:  next_rdata = pstage[32*pwin +: 32];
          default:           next_rdata = 32'h0000_0000;
        endcase
      end
    end
    next_irq_st = next_irq_st | ev; // set wins over clear
    next_irq = |(next_irq_st & mask[`DSLI_IRQ_BITS-1:0]);
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl       <= `DSLI_CTRL_RESET;
      mask       <= `DSLI_MASK_RESET;
      pidx       <= '0;
      pwin       <= '0;
      pstage     <= '0;
      pwe        <= 1'b0;
      rdata_q    <= '0;
      ack        <= 1'b0;
      irq_st     <= '0;
      irq_q      <= 1'b0;
      prev_ready <= 1'b0;
      prev_perm  <= 1'b0;
      prev_pwr   <= 1'b0;
    end else if (ce) begin
      ctrl       <= next_ctrl;
      mask       <= next_mask;
      pidx       <= next_pidx;
      pwin       <= next_pwin;
      pstage     <= next_pstage;
      pwe        <= next_pwe;
      rdata_q    <= next_rdata;
      ack        <= next_ack;
      irq_st     <= next_irq_st;
      irq_q      <= next_irq;
      prev_ready <= ready;
      prev_perm  <= perm_s;
      prev_pwr   <= pwr_s;
    end
  end
  // request held until the cycle after ack registers
  assign avs_waitrequest = !ack;
  assign avs_readdata    = rdata_q;
  assign irq             = irq_q;
endmodule

// ==== bench/dsli_led_monitor.sv ====
// checker of lamp and bus behaviour at the top ports
`timescale 1ns/1ps
`include "dsli_map.svh"
module dsli_led_monitor #(
  parameter int SLOT_CYCLES = 4
) (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       enable_a,
  input wire logic       enable_b,
  input wire logic       dc_bus_ok,
  input wire logic       motor_overtemp,
  input wire logic       module_overtemp,
  input wire logic       feedback_fault,
  input wire logic       temp_sensor_fault,
  input wire logic       temp_error,
  input wire logic       perm_error,
  input wire logic       power_stage_on,
  input wire logic [3:0] avs_address,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire dsli_pkg::dsli_word_t avs_writedata,
  input wire logic       avs_waitrequest,
  input wire logic       led_green,
  input wire logic       led_orange,
  input wire logic       led_red
);
  import dsli_pkg::*;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  localparam int BLINK_MAX = 2 * SLOT_CYCLES + 4;
  logic       os_ok, ovr, g_q, nrdy, rdy;
  logic [2:0] up;
  int         nr_cnt, stab;
  assign nrdy = !enable_a || !enable_b || !dc_bus_ok || motor_overtemp || module_overtemp
              || feedback_fault || temp_sensor_fault || temp_error || perm_error;
  assign rdy = !nrdy && os_ok && !ovr;
  // os bit mirrored from accepted writes, may lag the design by a cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      os_ok <= 1'b0;
      ovr <= 1'b0;
      g_q <= 1'b0;
      up <= 3'h0;
      nr_cnt <= 0;
      stab <= 0;
    end else begin
      if (avs_write && !avs_waitrequest && avs_address == `DSLI_ADDR_CTRL) begin
        os_ok <= avs_writedata[`DSLI_CTRL_OS_OK];
        ovr <= avs_writedata[`DSLI_CTRL_OVR_EN];
      end
      g_q <= led_green;
      up <= (up == 3'h4) ? up : up + 3'h1;
      nr_cnt <= (nrdy && os_ok && !ovr) ? ((nr_cnt > BLINK_MAX) ? nr_cnt : nr_cnt + 1) : 0;
      stab <= (led_green != g_q) ? 0 : stab + 1;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // table override drives the lamps directly, so the level checks except a_unbooted_dark stand aside
  a_orange_run: assert property (up == 3'h4 && !ovr |-> led_orange == $past(power_stage_on, 3))
    else $error("orange lamp mismatch");
  a_red_error: assert property (up == 3'h4 && !ovr |-> led_red == $past(perm_error, 3))
    else $error("red lamp mismatch");
  a_ready_steady: assert property (rdy [*5] |-> led_green)
    else $error("green not lit while ready");
  a_unbooted_dark: assert property ((!os_ok) [*5] |-> !led_green)
    else $error("green lit before boot");
  a_blink_moves: assert property (nr_cnt > BLINK_MAX |-> stab <= BLINK_MAX)
    else $error("green steady while not ready");
  a_slot_whole: assert property (nr_cnt > BLINK_MAX && led_green != g_q |->
    stab == SLOT_CYCLES - 1) else $error("blink step not one slot");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered");
  a_bus_idle: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("bus answered without request");
  c_blink: cover property (nr_cnt > BLINK_MAX && led_green != g_q);
  c_run_err: cover property (led_orange && led_red);
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule
bind dsli_led_top dsli_led_monitor #(.SLOT_CYCLES(SLOT_CYCLES)) mon (.clk, .nrst, .enable_a,
  .enable_b, .dc_bus_ok, .motor_overtemp, .module_overtemp, .feedback_fault,
  .temp_sensor_fault, .temp_error, .perm_error, .power_stage_on, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_waitrequest, .led_green, .led_orange, .led_red);

// ==== bench/dsli_lamp_panel.sv ====
// model of the three front-panel lamps
`timescale 1ns/1ps
module dsli_lamp_panel (
  input  wire logic green,
  input  wire logic orange,
  input  wire logic red,
  input  wire logic clk,
  input  wire logic nrst,
  output int        flips
);
  logic g_q;
  // a lamp only shows levels, so blinking is seen as green transitions
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      g_q <= 1'b0;
      flips <= 0;
    end else begin
      g_q <= green;
      flips <= flips + ((green != g_q) ? 1 : 0);
    end
  end
endmodule

// ==== bench/dsli_led_tb_top.sv ====
// self-checking bench of the lamp block
`timescale 1ns/1ps
`include "dsli_map.svh"
module dsli_led_tb_top;
  import dsli_pkg::*;
  // ----------------------------------------
  // stimulus and instances
  // ----------------------------------------
  localparam int S = 4;
  logic       clk, nrst, ps_on, perm, rd, wr, wreq, irq, g, o, r;
  logic [7:0] bad;
  logic [3:0] addr;
  dsli_word_t wdata, rdata;
  int         errors, comparisons, cyc, flips;
  dsli_led_top #(.SLOT_CYCLES(S)) uut (.clk(clk), .nrst(nrst), .ce(1'b1),
    .enable_a(!bad[0]), .enable_b(!bad[1]), .dc_bus_ok(!bad[2]), .motor_overtemp(bad[3]),
    .module_overtemp(bad[4]), .feedback_fault(bad[5]), .temp_sensor_fault(bad[6]),
    .temp_error(bad[7]), .perm_error(perm), .power_stage_on(ps_on), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .led_green(g), .led_orange(o), .led_red(r), .irq(irq));
  dsli_lamp_panel panel (.green(g), .orange(o), .red(r), .clk(clk), .nrst(nrst), .flips(flips));
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // no cycle count assumed: waits for the slave, the global timeout cuts a hang
  task automatic bus(input logic w, input logic [3:0] a, input dsli_word_t d,
                     output dsli_word_t q);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    dsli_word_t q;
    bus(0, `DSLI_ADDR_CTRL, 0, q);
    check(q, `DSLI_CTRL_RESET);
    bus(0, `DSLI_ADDR_MASK, 0, q);
    check(q, `DSLI_MASK_RESET);
    bus(0, 4'hf, 0, q);
    check(q, 32'h0);
    check(g, 1'b0);
  endtask
  task automatic t_ready();
    dsli_word_t q;
    int f;
    bus(1, `DSLI_ADDR_MASK, 32'h1, q);
    bus(1, `DSLI_ADDR_CTRL, 32'h2, q);
    tick(2 * S + 8);
    f = flips;
    tick(3 * S);
    check(g, 1'b1);
    check(32'(flips - f), 32'h0);
    check(irq, 1'b1);
    bus(1, `DSLI_ADDR_IRQ, 32'h1, q);
    tick(2);
    check(irq, 1'b0);
  endtask
  task automatic t_not_ready();
    dsli_word_t q;
    int f;
    for (int i = 0; i < 8; i++) begin
      bad <= 8'h1 << i;
      tick(2);
      f = flips;
      tick(5 * S);
      check(32'((flips - f) >= 3), 32'h1);
      bad <= 8'h0;
      tick(S + 6);
      check(g, 1'b1);
    end
    check(irq, 1'b1);
    bus(1, `DSLI_ADDR_MASK, 32'h0, q);
    tick(2);
    check(irq, 1'b0);
    bus(0, `DSLI_ADDR_IRQ, 0, q);
    check(q, 32'h3);
    bus(1, `DSLI_ADDR_IRQ, 32'hf, q);
    bus(0, `DSLI_ADDR_IRQ, 0, q);
    check(q, 32'h0);
  endtask
  task automatic t_run_err();
    dsli_word_t q;
    ps_on <= 1'b1;
    tick(4);
    check(o, 1'b1);
    perm <= 1'b1;
    tick(4);
    check(r, 1'b1);
    bus(0, `DSLI_ADDR_IRQ, 0, q);
    check(q, 32'he);
    bus(1, `DSLI_ADDR_MASK, 32'h4, q);
    tick(2);
    check(irq, 1'b1);
    ps_on <= 1'b0;
    perm <= 1'b0;
    tick(4);
    check({o, r}, 2'b00);
    bus(1, `DSLI_ADDR_IRQ, 32'hf, q);
  endtask
  task automatic t_pattern();
    dsli_word_t q;
    bus(1, `DSLI_ADDR_PINDEX, 32'h1, q);
    for (int w = 0; w < 3; w++) begin
      bus(1, `DSLI_ADDR_PWIN, 32'(w), q);
      bus(1, `DSLI_ADDR_PDATA, 32'hffff_ffff, q);
    end
    // select the entry before the override, the table read lags one cycle
    bus(1, `DSLI_ADDR_CTRL, 32'h12, q);
    bus(1, `DSLI_ADDR_CTRL, 32'h13, q);
    tick(S + 4);
    check({g, o, r}, 3'b111);
    bus(1, `DSLI_ADDR_CTRL, 32'h2, q);
    tick(4);
    check({g, o, r}, 3'b100);
    bus(1, `DSLI_ADDR_IRQ, 32'hf, q);
  endtask
  task automatic t_period();
    dsli_word_t q;
    logic [4:0] s;
    s = 5'h0;
    for (int n = 0; n < 200 && s != 5'h17; n++) begin
      bus(0, `DSLI_ADDR_STATUS, 0, q);
      s = q[9:5];
    end
    check(s, 5'h17);
    while (s == 5'h17) begin
      bus(0, `DSLI_ADDR_STATUS, 0, q);
      s = q[9:5];
    end
    check(s, 5'h0);
  endtask
  task automatic final_report();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    {nrst, ps_on, perm, rd, wr, bad, addr, wdata} = '0;
    tick(4);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    t_ready();
    t_not_ready();
    t_run_err();
    t_pattern();
    t_period();
    final_report();
  end
endmodule
